/* File: core/port_role_pkg.sv */
// ============================================================
// shared constants and types for the port role block
package port_role_pkg;

    // clock period in picoseconds (40 MHz)
    localparam int unsigned CLK_PERIOD_PS = 25000;

    // least low time on the strobe pin that forces a reset, in ns
    localparam int unsigned STROBE_RESET_NS = 44000;
    // same time in clock cycles, rounded up
    localparam int unsigned STROBE_RESET_CYCLES =
        (STROBE_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // least below-threshold time before a power fail shows, in ns
    localparam int unsigned POWER_FAIL_NS = 700000;
    // same time in clock cycles, rounded up
    localparam int unsigned POWER_FAIL_CYCLES =
        (POWER_FAIL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // cycles spent reading the configuration memory after reset
    localparam logic [4:0] INIT_CYCLES = 5'h10;
    // counter widths
    localparam int unsigned STROBE_CNT_W = 11;
    localparam int unsigned POWER_CNT_W = 16;

    // positions inside the synchronised pin vector
    localparam int unsigned PIN_ADDR = 4;
    localparam int unsigned PIN_FAULT = 5;
    localparam int unsigned PIN_STROBE = 6;
    localparam int unsigned PIN_W = 7;

    // positions of the monitor error flags on the data output port
    localparam int unsigned ERR_PULSE = 0;
    localparam int unsigned ERR_INFO = 1;
    localparam int unsigned ERR_PARITY = 2;
    localparam int unsigned ERR_CODING = 3;

    // values after reset
    localparam logic [3:0] DATA_OUT_RESET = 4'hF;
    localparam logic [3:0] ERR_RESET = 4'h0;

    // operating modes held in configuration memory
    typedef enum logic [1:0] {
        MODE_SLAVE = 2'h0,
        MODE_MASTER = 2'h1,
        MODE_REPEATER = 2'h2,
        MODE_MONITOR = 2'h3
    } op_mode_e;

    // start-up sequence states
    typedef enum logic {
        ST_INIT = 1'b0,
        ST_RUN = 1'b1
    } init_state_e;

endpackage : port_role_pkg

/* File: core/port_role_and_fault_sense.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (RULE_01) addressing input inverted when bits zero, one differ
// (RULE_02) first lamp inverted when bits two, three differ
// (RULE_03) data outputs show errors only in monitor
// (RULE_04) error set on detection, cleared at telegram start
// (RULE_05) bit zero: alternation, start or end error
// (RULE_06) bit one: no-information or length error
// (RULE_07) bit two: parity mismatch
// (RULE_08) bit three: addressing-channel coding violation
// (RULE_09) strobe pin also acts as reset input
// (RULE_10) strobe held low long enough forces reset
// (RULE_11) after strobe reset, reload configuration memory
// (RULE_12) slave mode: status bit from fault input
// (RULE_13) polarity flag clear: status equals fault level
// (RULE_14) polarity flag set: fault input inverted first
// (RULE_15) fault input synchronised before status bit
// (RULE_16) master or monitor: long low means power fail
// (RULE_17) no power fail during initialisation
// (RULE_18) equal lamp controls: high active, idle zero
// (RULE_19) port roles follow mode loaded at initialisation
// (RULE_20) power fail counter restarts when input recovers
module port_role_and_fault_sense #(
    parameter int unsigned POWER_FAIL_LIMIT = port_role_pkg::POWER_FAIL_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // configuration memory contents
    input wire port_role_pkg::op_mode_e cfg_mode,
    input wire logic fault_sense_polarity_flag,
    // pins
    input wire logic [3:0] data_in_pins,
    input wire logic addr_channel_pin,
    input wire logic fault_sense_input,
    // strobe pin, open drain
    input wire logic strobe_pin_in,
    output logic strobe_pin_out,
    output logic strobe_pin_oe_n,
    // internal logic on the same clock
    input wire logic strobe_request,
    input wire logic lamp_one_raw,
    input wire logic [3:0] slave_data_out,
    input wire logic telegram_start,
    input wire logic alternation_err,
    input wire logic start_bit_err,
    input wire logic end_bit_err,
    input wire logic no_info_err,
    input wire logic length_err,
    input wire logic parity_err,
    input wire logic coding_err,
    // outputs
    output logic [3:0] data_out_pins,
    output logic addr_channel_proc,
    output logic status_lamp_one,
    output logic slave_status_bit_one,
    output logic parameter_pin_one,
    output logic init_busy,
    output port_role_pkg::op_mode_e active_mode
);
    import port_role_pkg::*;

    // ============================================================
    // pin synchronisers
    logic [PIN_W-1:0] pin_meta_reg; // first stage, read only by second
    logic [PIN_W-1:0] pin_sync_reg; // second stage
    logic [PIN_W-1:0] pin_raw; // gathered pins

    // gather the asynchronous pins
    always_comb begin
        pin_raw = {strobe_pin_in, fault_sense_input, addr_channel_pin, data_in_pins};
    end

    // two flip-flops for every pin
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta_reg <= '1;
            pin_sync_reg <= '1;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ============================================================
    // strobe pin reset detector
    logic [STROBE_CNT_W-1:0] strobe_cnt_reg, strobe_cnt_next; // low-time counter
    logic ext_reset_reg, ext_reset_next; // one-cycle reset pulse
    logic strobe_drive_reg, strobe_drive_next; // device pulls pin low
    logic strobe_low; // pin low, not from our own drive
    logic core_reset; // reset for all block state except the pin synchronisers and the strobe detector

    // count low time of the pin when the device itself is not pulling
    always_comb begin
        strobe_low = !pin_sync_reg[PIN_STROBE] && !strobe_drive_reg; // [RULE_09]
        strobe_drive_next = strobe_request;
        strobe_cnt_next = '0;
        ext_reset_next = 1'b0;
        if (strobe_low) begin
            // saturate so one long pull gives one reset
            if (strobe_cnt_reg == STROBE_CNT_W'(STROBE_RESET_CYCLES)) begin
                strobe_cnt_next = strobe_cnt_reg;
            end else begin
                strobe_cnt_next = strobe_cnt_reg + 1'b1;
            end
            // reached the least reset time
            if (strobe_cnt_reg == STROBE_CNT_W'(STROBE_RESET_CYCLES - 1)) begin
                ext_reset_next = 1'b1; // [RULE_10]
            end
        end
    end

    // register the detector, the pin drive and the reset pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            strobe_cnt_reg <= '0;
            ext_reset_reg <= 1'b0;
            strobe_drive_reg <= 1'b0;
            strobe_pin_oe_n <= 1'b1; // pin released
        end else begin
            strobe_cnt_reg <= strobe_cnt_next;
            ext_reset_reg <= ext_reset_next;
            strobe_drive_reg <= strobe_drive_next;
            strobe_pin_oe_n <= !strobe_drive_next; // low while pulling the pin
        end
    end

    // open drain: only ever drives low, enable registered above
    always_comb begin
        core_reset = reset || ext_reset_reg; // [RULE_10]
        strobe_pin_out = 1'b0;
    end

    // ============================================================
    // initialisation and configuration load
    init_state_e state_reg, state_next; // start-up state
    logic [4:0] init_cnt_reg, init_cnt_next; // read-out timer
    op_mode_e mode_reg, mode_next; // loaded operating mode
    logic polarity_reg, polarity_next; // loaded fault polarity flag

    // read the configuration memory, then run
    always_comb begin
        state_next = state_reg;
        init_cnt_next = init_cnt_reg;
        mode_next = mode_reg;
        polarity_next = polarity_reg;
        unique case (state_reg)
            ST_INIT: begin
                init_cnt_next = init_cnt_reg + 1'b1;
                // read-out done: latch configuration
                if (init_cnt_reg == INIT_CYCLES - 1'b1) begin
                    mode_next = cfg_mode; // [RULE_19]
                    polarity_next = fault_sense_polarity_flag;
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                init_cnt_next = '0;
            end
        endcase
    end

    // any reset, pin or system, restarts the read-out
    always_ff @(posedge clk) begin
        if (core_reset) begin
            state_reg <= ST_INIT; // [RULE_11]
            init_cnt_reg <= '0;
            mode_reg <= MODE_SLAVE;
            polarity_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            init_cnt_reg <= init_cnt_next;
            mode_reg <= mode_next;
            polarity_reg <= polarity_next;
        end
    end

    // ============================================================
    // mode dependent port roles
    logic control_mode; // master, repeater or monitor
    logic monitor_mode; // monitor only
    logic fault_level; // fault input after polarity
    logic [3:0] err_reg, err_next; // active high error flags
    logic [3:0] err_event; // error detections this cycle
    logic [3:0] data_out_next;
    logic addr_next, lamp_next, status_next;

    // decode mode and compute the port functions
    always_comb begin
        control_mode = (mode_reg != MODE_SLAVE) && (state_reg == ST_RUN);
        monitor_mode = (mode_reg == MODE_MONITOR) && (state_reg == ST_RUN);
        // error sources grouped per output bit
        err_event[ERR_PULSE] = alternation_err || start_bit_err || end_bit_err; // [RULE_05]
        err_event[ERR_INFO] = no_info_err || length_err; // [RULE_06]
        err_event[ERR_PARITY] = parity_err; // [RULE_07]
        err_event[ERR_CODING] = coding_err; // [RULE_08]
        // new detection wins over the telegram start clear
        if (telegram_start) begin
            err_next = err_event; // [RULE_04]
        end else begin
            err_next = err_reg | err_event; // [RULE_04]
        end
        // data port role
        if (monitor_mode) begin
            data_out_next = ~err_next; // [RULE_03]
        end else if (control_mode) begin
            data_out_next = DATA_OUT_RESET;
        end else begin
            data_out_next = slave_data_out;
        end
        // polarity controls on the data inputs
        addr_next = pin_sync_reg[PIN_ADDR];
        lamp_next = lamp_one_raw;
        if (control_mode) begin
            addr_next = pin_sync_reg[PIN_ADDR] ^ pin_sync_reg[0] ^ pin_sync_reg[1]; // [RULE_01]
            lamp_next = lamp_one_raw ^ pin_sync_reg[2] ^ pin_sync_reg[3]; // [RULE_02] [RULE_18]
        end
        // fault input after the synchroniser and polarity flag
        fault_level = pin_sync_reg[PIN_FAULT] ^ polarity_reg; // [RULE_13] [RULE_14] [RULE_15]
        status_next = (mode_reg == MODE_SLAVE) ? fault_level : 1'b0; // [RULE_12]
    end

    // register the port outputs
    always_ff @(posedge clk) begin
        if (core_reset) begin
            err_reg <= ERR_RESET;
            data_out_pins <= DATA_OUT_RESET;
            addr_channel_proc <= 1'b0;
            status_lamp_one <= 1'b0;
            slave_status_bit_one <= 1'b0;
        end else begin
            err_reg <= err_next;
            data_out_pins <= data_out_next;
            addr_channel_proc <= addr_next;
            status_lamp_one <= lamp_next;
            slave_status_bit_one <= status_next;
        end
    end

    // ============================================================
    // power fail detector
    logic [POWER_CNT_W-1:0] pf_cnt_reg, pf_cnt_next; // below-threshold time
    logic pf_next; // power fail level
    logic pf_mode; // master or monitor, running

    // count while the comparator reports low; restart on recovery
    always_comb begin
        pf_mode = ((mode_reg == MODE_MASTER) || (mode_reg == MODE_MONITOR))
            && (state_reg == ST_RUN);
        pf_cnt_next = '0;
        if (pf_mode && !pin_sync_reg[PIN_FAULT]) begin
            if (pf_cnt_reg == POWER_CNT_W'(POWER_FAIL_LIMIT)) begin
                pf_cnt_next = pf_cnt_reg;
            end else begin
                pf_cnt_next = pf_cnt_reg + 1'b1; // [RULE_20]
            end
        end
        pf_next = pf_mode && (pf_cnt_next == POWER_CNT_W'(POWER_FAIL_LIMIT)); // [RULE_16] [RULE_17]
    end

    // register the detector and start-up outputs
    always_ff @(posedge clk) begin
        if (core_reset) begin
            pf_cnt_reg <= '0;
            parameter_pin_one <= 1'b0;
            init_busy <= 1'b1;
            active_mode <= MODE_SLAVE;
        end else begin
            pf_cnt_reg <= pf_cnt_next;
            parameter_pin_one <= pf_next;
            init_busy <= (state_next == ST_INIT);
            active_mode <= mode_next;
        end
    end

    // ============================================================
    // assertions
    a_addr_invert: // [RULE_01]
    assert property (@(posedge clk) disable iff (core_reset)
        control_mode |=> addr_channel_proc == ($past(pin_sync_reg[PIN_ADDR])
            ^ $past(pin_sync_reg[0]) ^ $past(pin_sync_reg[1])))
        else $error("addressing input polarity wrong");
    a_lamp_invert: // [RULE_02]
    assert property (@(posedge clk) disable iff (core_reset)
        control_mode |=> status_lamp_one == ($past(lamp_one_raw)
            ^ $past(pin_sync_reg[2]) ^ $past(pin_sync_reg[3])))
        else $error("lamp polarity wrong");
    a_err_only_monitor: // [RULE_03]
    assert property (@(posedge clk) disable iff (core_reset)
        (control_mode && !monitor_mode) |=> data_out_pins == DATA_OUT_RESET)
        else $error("error flags outside monitor mode");
    a_err_pulse_set: // [RULE_05]
    assert property (@(posedge clk) disable iff (core_reset)
        (monitor_mode && (alternation_err || start_bit_err || end_bit_err))
        |=> !data_out_pins[ERR_PULSE])
        else $error("pulse code error not flagged");
    a_err_clear_start: // [RULE_04]
    assert property (@(posedge clk) disable iff (core_reset)
        (monitor_mode && telegram_start && !parity_err) |=> data_out_pins[ERR_PARITY])
        else $error("parity flag not cleared at telegram start");
    a_err_info_hold: // [RULE_06]
    assert property (@(posedge clk) disable iff (core_reset)
        (monitor_mode && length_err) ##1 (monitor_mode && !telegram_start)[*2]
        |=> !data_out_pins[ERR_INFO])
        else $error("info error flag dropped early");

    a_coding_set: // [RULE_08]
    assert property (@(posedge clk) disable iff (core_reset)
        (monitor_mode && coding_err) |=> !data_out_pins[ERR_CODING])
        else $error("coding error not flagged");

    a_strobe_reset: // [RULE_10]
    assert property (@(posedge clk) disable iff (reset)
        ext_reset_reg |=> init_busy ##[1:20] !init_busy)
        else $error("strobe reset did not restart initialisation");

    a_status_fault: // [RULE_12]
    assert property (@(posedge clk) disable iff (core_reset)
        (mode_reg == MODE_SLAVE) |=> slave_status_bit_one
            == ($past(pin_sync_reg[PIN_FAULT]) ^ $past(polarity_reg)))
        else $error("status bit does not follow fault input");

    a_pf_quiet_init: // [RULE_17]
    assert property (@(posedge clk) disable iff (reset)
        init_busy |-> !parameter_pin_one)
        else $error("power fail during initialisation");

    a_pf_restart: // [RULE_20]
    assert property (@(posedge clk) disable iff (core_reset)
        pin_sync_reg[PIN_FAULT] |=> pf_cnt_reg == '0 ##1 !parameter_pin_one)
        else $error("power fail counter not restarted");

    c_monitor_error: cover property (@(posedge clk) monitor_mode && !data_out_pins[ERR_PARITY]);
    c_power_fail: cover property (@(posedge clk) $rose(parameter_pin_one));
    c_strobe_reset: cover property (@(posedge clk) ext_reset_reg);
    c_lamp_inverted: cover property (@(posedge clk)
        control_mode && (pin_sync_reg[2] != pin_sync_reg[3]));

endmodule : port_role_and_fault_sense

/* File: tb/pin_partner.sv */
`timescale 1ns/1ps
// ==========
// far side: controller driving the data, fault and strobe pins
module pin_partner (
    // clock
    input wire logic clk,
    // commands from the bench
    input wire logic [3:0] data_cmd,
    input wire logic fault_cmd,
    input wire logic strobe_hold,
    // device drive of the strobe line
    input wire logic strobe_pin_oe_n,
    // pins
    output logic [3:0] data_in_pins = 4'h0,
    output logic fault_sense_input = 1'b1,
    output logic strobe_pin_in
);
    // pins follow the commands through an external register
    always @(posedge clk) begin
        data_in_pins <= data_cmd;
        fault_sense_input <= fault_cmd;
    end
    // open drain with pull-up: low while either side pulls
    assign strobe_pin_in = ~(strobe_hold | ~strobe_pin_oe_n);
endmodule : pin_partner

/* File: tb/tb_port_role_and_fault_sense.sv */
`timescale 1ns/1ps
// ==========
// bench for the port role block
module tb_port_role_and_fault_sense;
    import port_role_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    op_mode_e cfg_mode = MODE_SLAVE;
    logic fault_sense_polarity_flag = 1'b0;
    logic [3:0] data_cmd = 4'h0;
    logic fault_cmd = 1'b1;
    logic strobe_hold = 1'b0;
    logic addr_channel_pin = 1'b0;
    logic strobe_request = 1'b0;
    logic lamp_one_raw = 1'b0;
    logic [3:0] slave_data_out = 4'h0;
    logic telegram_start = 1'b0;
    logic [6:0] err_v = 7'h00; // detection pulses
    // device side
    logic [3:0] data_in_pins;
    logic fault_sense_input;
    logic strobe_pin_in;
    logic strobe_pin_out;
    logic strobe_pin_oe_n;
    logic [3:0] data_out_pins;
    logic addr_channel_proc;
    logic status_lamp_one;
    logic slave_status_bit_one;
    logic parameter_pin_one;
    logic init_busy;
    op_mode_e active_mode;
    int mismatches = 0;
    int n_compared = 0;
    // ==========
    // clock, 25 ns
    initial begin
        forever #12.5 clk = ~clk;
    end
    pin_partner pin_partner_inst (.clk(clk), .data_cmd(data_cmd), .fault_cmd(fault_cmd),
        .strobe_hold(strobe_hold), .strobe_pin_oe_n(strobe_pin_oe_n),
        .data_in_pins(data_in_pins), .fault_sense_input(fault_sense_input),
        .strobe_pin_in(strobe_pin_in));
    port_role_and_fault_sense #(.POWER_FAIL_LIMIT(40)) port_role_and_fault_sense_inst (
        .clk(clk), .reset(reset), .cfg_mode(cfg_mode),
        .fault_sense_polarity_flag(fault_sense_polarity_flag),
        .data_in_pins(data_in_pins), .addr_channel_pin(addr_channel_pin),
        .fault_sense_input(fault_sense_input), .strobe_pin_in(strobe_pin_in),
        .strobe_pin_out(strobe_pin_out), .strobe_pin_oe_n(strobe_pin_oe_n),
        .strobe_request(strobe_request), .lamp_one_raw(lamp_one_raw),
        .slave_data_out(slave_data_out), .telegram_start(telegram_start),
        .alternation_err(err_v[0]), .start_bit_err(err_v[1]), .end_bit_err(err_v[2]),
        .no_info_err(err_v[3]), .length_err(err_v[4]), .parity_err(err_v[5]),
        .coding_err(err_v[6]), .data_out_pins(data_out_pins),
        .addr_channel_proc(addr_channel_proc), .status_lamp_one(status_lamp_one),
        .slave_status_bit_one(slave_status_bit_one), .parameter_pin_one(parameter_pin_one),
        .init_busy(init_busy), .active_mode(active_mode));
    // ==========
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // compare a value of up to four bits
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // wait for the configuration read-out to end, bounded
    task automatic wait_init(input op_mode_e m);
        int k;
        k = 0;
        while (init_busy !== 1'b0 && k < 40) begin
            tick(1);
            k++;
        end
        check({3'h0, init_busy}, 4'h0);
        check({2'h0, active_mode}, {2'h0, m});
    endtask : wait_init
    task automatic do_reset(input op_mode_e m, input logic f);
        @(posedge clk);
        reset <= 1'b1;
        cfg_mode <= m;
        fault_sense_polarity_flag <= f;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        tick(1);
        check({3'h0, init_busy}, 4'h1);
        check({3'h0, parameter_pin_one}, 4'h0);
        wait_init(m);
    endtask : do_reset
    // one-cycle detection and telegram start pulses
    task automatic pulse(input logic [6:0] e, input logic t);
        @(posedge clk);
        err_v <= e;
        telegram_start <= t;
        @(posedge clk);
        err_v <= 7'h00;
        telegram_start <= 1'b0;
        #1;
    endtask : pulse
    // ==========
    // scenarios
    task automatic t_polarity(input op_mode_e m);
        logic [3:0] d;
        do_reset(m, 1'b0);
        for (int i = 0; i < 16; i++) begin
            d = i[3:0];
            @(posedge clk);
            data_cmd <= d;
            addr_channel_pin <= d[0] ^ d[2];
            lamp_one_raw <= d[1];
            tick(6);
            check({3'h0, addr_channel_proc}, {3'h0, d[2] ^ d[1]});
            check({3'h0, status_lamp_one}, {3'h0, d[1] ^ d[2] ^ d[3]});
        end
    endtask : t_polarity
    task automatic t_errors();
        logic [3:0] exp;
        int b;
        do_reset(MODE_MONITOR, 1'b0);
        for (int i = 0; i < 7; i++) begin
            b = (i < 3) ? 0 : (i < 5) ? 1 : i - 3;
            exp = 4'hF;
            exp[b] = 1'b0;
            pulse(7'h01 << i, 1'b0);
            check(data_out_pins, exp);
            tick(3);
            check(data_out_pins, exp);
            pulse(7'h00, 1'b1);
            check(data_out_pins, 4'hF);
        end
        pulse(7'h20, 1'b1);
        check(data_out_pins, 4'hB);
        do_reset(MODE_REPEATER, 1'b0);
        pulse(7'h7F, 1'b0);
        check(data_out_pins, 4'hF);
    endtask : t_errors
    task automatic t_slave(input logic f);
        do_reset(MODE_SLAVE, f);
        @(posedge clk);
        slave_data_out <= 4'hA;
        data_cmd <= 4'h1;
        addr_channel_pin <= 1'b1;
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            fault_cmd <= v[0];
            tick(2);
            check({3'h0, slave_status_bit_one}, {3'h0, ~v[0] ^ f});
            tick(4);
            check({3'h0, slave_status_bit_one}, {3'h0, v[0] ^ f});
        end
        check(data_out_pins, 4'hA);
        check({3'h0, addr_channel_proc}, 4'h1);
    endtask : t_slave
    task automatic t_power(input op_mode_e m, input logic exp_pf);
        @(posedge clk);
        fault_cmd <= 1'b1;
        do_reset(m, 1'b0);
        @(posedge clk);
        fault_cmd <= 1'b0;
        tick(30);
        check({3'h0, parameter_pin_one}, 4'h0);
        @(posedge clk);
        fault_cmd <= 1'b1;
        tick(4);
        @(posedge clk);
        fault_cmd <= 1'b0;
        tick(30);
        check({3'h0, parameter_pin_one}, 4'h0);
        tick(20);
        check({3'h0, parameter_pin_one}, {3'h0, exp_pf});
        @(posedge clk);
        fault_cmd <= 1'b1;
        tick(6);
        check({3'h0, parameter_pin_one}, 4'h0);
    endtask : t_power
    task automatic t_strobe();
        int k;
        do_reset(MODE_MASTER, 1'b0);
        @(posedge clk);
        strobe_request <= 1'b1;
        tick(2);
        check({strobe_pin_out, strobe_pin_oe_n, 2'h0}, 4'h0);
        tick(1800);
        check({3'h0, init_busy}, 4'h0);
        @(posedge clk);
        strobe_request <= 1'b0;
        cfg_mode <= MODE_MONITOR;
        strobe_hold <= 1'b1;
        k = 0;
        tick(1);
        while (init_busy !== 1'b1 && k < 1800) begin
            tick(1);
            k++;
        end
        check({3'h0, k > 1740 && k < 1780}, 4'h1);
        @(posedge clk);
        strobe_hold <= 1'b0;
        wait_init(MODE_MONITOR);
    endtask : t_strobe
    // ==========
    // closing and watchdog
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        #(25 * 20000);
        mismatches++;
        test_done();
    end
    initial begin
        t_polarity(MODE_MASTER);
        t_polarity(MODE_REPEATER);
        t_polarity(MODE_MONITOR);
        t_errors();
        t_slave(1'b0);
        t_slave(1'b1);
        t_power(MODE_MASTER, 1'b1);
        t_power(MODE_MONITOR, 1'b1);
        t_power(MODE_REPEATER, 1'b0);
        t_power(MODE_SLAVE, 1'b0);
        t_strobe();
        test_done();
    end
endmodule : tb_port_role_and_fault_sense
